//--- core/rss_defines.svh
// named constants for the addressed serial switch
`ifndef RSS_DEFINES_SVH
`define RSS_DEFINES_SVH

// ==========================================
// timing
`define RSS_CLK_HZ 125000000
`define RSS_CMD_BAUD 9600
`define RSS_SYNC_STAGES 3

// ==========================================
// command characters
`define RSS_CHAR_XOFF 8'h13
`define RSS_CHAR_SOH 8'h01

// ==========================================
// ascii ranges of hexadecimal digits
`define RSS_ASC_0 8'h30
`define RSS_ASC_9 8'h39
`define RSS_ASC_UA 8'h41
`define RSS_ASC_UF 8'h46
`define RSS_ASC_LA 8'h61
`define RSS_ASC_LF 8'h66
`define RSS_HEX_TEN 4'hA

// ==========================================
// framing and storage
`define RSS_DATA_BITS 8
`define RSS_STOP_IDX 4'h9
`define RSS_START_IDX 4'h0
`define RSS_FIFO_DEPTH 16
`define RSS_ADDR_RESET 8'h00

`endif

//--- core/rss_fifo.sv
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/10ps
module rss_fifo #(
	parameter int WIDTH = 9,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	// storage and pointers, one extra bit tells full from empty
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [AW:0] wr_q;
	logic [AW:0] rd_q;
	logic push;
	logic pop;

	assign in_ready = !((wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]));
	assign out_valid = (wr_q != rd_q);
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_q[rd_q[AW-1:0]];

	// ==========================================
	// write side
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wr_q <= '0;
		end else if (push) begin
			wr_q <= wr_q + 1'b1;
		end
	end

	// memory has no reset, contents are only read when valid
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_q[wr_q[AW-1:0]] <= in_data;
		end
	end

	// ==========================================
	// read side
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			rd_q <= '0;
		end else if (pop) begin
			rd_q <= rd_q + 1'b1;
		end
	end
endmodule

//--- core/rss_pkg.sv
// shared types for the addressed serial switch
package rss_pkg;
	// one received command character and its framing verdict
	typedef struct packed {
		logic [7:0] data;
		logic bad;
	} rss_char_t;

	// command decoder states, one-hot
	typedef enum logic [3:0] {
		RSS_HUNT = 4'b0001,
		RSS_HIGH = 4'b0010,
		RSS_LOW = 4'b0100,
		RSS_TAIL = 4'b1000
	} rss_state_t;
endpackage

//--- core/rss_switch.sv
// addressed serial switch: command receiver, decoder and pass-through
// ==========================================
// What this block does
// [R1] command taken only from clean 9600 baud frames
// [R2] decode xoff, high digit, low digit, soh
// [R3] two hex digits give address 00 to ff
// [R4] station address from switches, reset default zero
// [R5] each station answers only its own address
// [R6] selected station forwards both directions
// [R7] forwarding is bitwise, unbuffered, rate independent
// [R8] command framing 9600, 8 data, no parity, 1 stop
// [R9] host may change rate once selected
// [R10] select indicator lights on address match
// [R11] strap picks two-wire or four-wire line
// [R12] other address deselects and darkens indicator
// [R13] non-hex address character restarts the hunt
`timescale 1ns/10ps
`include "rss_defines.svh"
module rss_switch #(
	parameter int BIT_CYCLES = `RSS_CLK_HZ / `RSS_CMD_BAUD,
	parameter int FIFO_DEPTH = `RSS_FIFO_DEPTH
) (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rx485_pin,
	output logic tx485_out,
	output logic tx485_oe_n,
	input wire logic rx232_pin,
	output logic tx232_out,
	input wire logic [7:0] addr_sw,
	input wire logic duplex4_strap,
	input wire logic cmd_pause,
	output logic sel_led,
	output logic char_overrun
);
	import rss_pkg::*;

	localparam int NPIN = 11;
	localparam int CW = $clog2(BIT_CYCLES + 1);
	localparam logic [CW-1:0] C_Q1 = CW'(BIT_CYCLES / 4);
	localparam logic [CW-1:0] C_MID = CW'(BIT_CYCLES / 2);
	localparam logic [CW-1:0] C_Q3 = CW'((BIT_CYCLES * 3) / 4);
	localparam logic [CW-1:0] C_END = CW'(BIT_CYCLES - 1);

	// ==========================================
	// pin synchronisers
	logic [NPIN-1:0] pin_raw;
	logic [NPIN-1:0] s1_q;
	logic [NPIN-1:0] s2_q;
	logic [NPIN-1:0] s3_q;
	logic [NPIN-1:0] pin_q; // filtered level, changes when stage 2 and 3 agree
	logic rx485_s;
	logic rx232_s;
	logic four_wire;
	logic [7:0] station_addr; // [R4]

	assign pin_raw = {addr_sw, duplex4_strap, rx232_pin, rx485_pin};

	genvar gi;
	generate
		for (gi = 0; gi < NPIN; gi++) begin : g_sync
			// three stages, first one feeds only the second
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					s1_q[gi] <= 1'b1;
					s2_q[gi] <= 1'b1;
					s3_q[gi] <= 1'b1;
				end else begin
					s1_q[gi] <= pin_raw[gi];
					s2_q[gi] <= s1_q[gi];
					s3_q[gi] <= s2_q[gi];
				end
			end
			// accept a new level once stages two and three agree
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					pin_q[gi] <= (gi < 3) ? 1'b1 : 1'b0;
				end else if (s2_q[gi] == s3_q[gi]) begin
					pin_q[gi] <= s3_q[gi];
				end
			end
		end
	endgenerate

	assign rx485_s = pin_q[0];
	assign rx232_s = pin_q[1];
	assign four_wire = pin_q[2]; // [R11]
	assign station_addr = pin_q[NPIN-1:3]; // [R4] switches weight bit 0 to bit 7

	// ==========================================
	// command receiver, fixed 9600 baud 8n1
	// each bit is sampled at quarter, middle and three quarters; a link
	// running at another rate breaks that agreement or the stop bit
	logic busy_q;
	logic [CW-1:0] tick_q;
	logic [3:0] bit_q;
	logic q1_q;
	logic mid_q;
	logic bad_q;
	logic [7:0] shift_q;
	logic push_q;
	rss_char_t char_q;
	logic fifo_in_ready;
	logic stop_done;

	assign stop_done = busy_q && (bit_q == `RSS_STOP_IDX) && (tick_q == C_Q3);

	// bit timing counter
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			busy_q <= 1'b0;
			tick_q <= '0;
			bit_q <= `RSS_START_IDX;
		end else if (!busy_q) begin
			busy_q <= !rx485_s;
			tick_q <= '0;
			bit_q <= `RSS_START_IDX;
		end else if (stop_done) begin
			busy_q <= 1'b0; // free early so the next start edge is caught
		end else if (bit_q == `RSS_START_IDX && tick_q == C_MID && rx485_s) begin
			busy_q <= 1'b0; // false start, a glitch
		end else if (tick_q == C_END) begin
			tick_q <= '0;
			bit_q <= bit_q + 4'h1;
		end else begin
			tick_q <= tick_q + 1'b1;
		end
	end

	// sample capture and rate check
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			q1_q <= 1'b1;
			mid_q <= 1'b1;
			bad_q <= 1'b0;
		end else if (!busy_q) begin
			bad_q <= 1'b0;
		end else begin
			if (tick_q == C_Q1) begin
				q1_q <= rx485_s;
			end
			if (tick_q == C_MID) begin
				mid_q <= rx485_s;
			end
			if (tick_q == C_Q3 && (q1_q != mid_q || rx485_s != mid_q)) begin
				bad_q <= 1'b1; // [R1]
			end
		end
	end

	// data bits, lsb first
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shift_q <= '0;
		end else if (busy_q && tick_q == C_MID && bit_q != `RSS_START_IDX
				&& bit_q != `RSS_STOP_IDX) begin
			shift_q <= {rx485_s, shift_q[7:1]}; // [R8]
		end
	end

	// hand a finished frame to the fifo, a bad frame is still passed on
	// so the decoder can drop any partial command
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			push_q <= 1'b0;
			char_q <= '0;
		end else begin
			push_q <= stop_done;
			char_q.data <= shift_q;
			char_q.bad <= bad_q || !mid_q || !rx485_s; // [R8] stop bit must be high
		end
	end

	// a frame that finds the fifo full is lost and flagged
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			char_overrun <= 1'b0;
		end else begin
			char_overrun <= push_q && !fifo_in_ready;
		end
	end

	// ==========================================
	// character fifo between receiver and decoder
	rss_char_t fifo_out;
	logic fifo_out_valid;
	logic dec_ready;
	logic take;

	assign dec_ready = !cmd_pause;
	assign take = fifo_out_valid && dec_ready;

	rss_fifo #(
		.WIDTH($bits(rss_char_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst(sys_rst),
		.in_valid(push_q),
		.in_ready(fifo_in_ready),
		.in_data(char_q),
		.out_valid(fifo_out_valid),
		.out_ready(dec_ready),
		.out_data(fifo_out)
	);

	// ==========================================
	// command decoder
	function automatic logic [4:0] hex_val(input logic [7:0] c);
		logic [4:0] r;
		r = 5'h10; // bit 4 marks not a hex digit
		if (c >= `RSS_ASC_0 && c <= `RSS_ASC_9) begin
			r = {1'b0, 4'(c - `RSS_ASC_0)};
		end else if (c >= `RSS_ASC_UA && c <= `RSS_ASC_UF) begin
			r = {1'b0, 4'(c - `RSS_ASC_UA) + `RSS_HEX_TEN};
		end else if (c >= `RSS_ASC_LA && c <= `RSS_ASC_LF) begin
			r = {1'b0, 4'(c - `RSS_ASC_LA) + `RSS_HEX_TEN};
		end
		return r;
	endfunction

	rss_state_t state_q;
	logic [3:0] hi_q;
	logic [7:0] cmd_addr_q;
	logic sel_q;
	logic [4:0] hv;

	assign hv = hex_val(fifo_out.data);

	// sequence tracking
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state_q <= RSS_HUNT;
			hi_q <= '0;
			cmd_addr_q <= `RSS_ADDR_RESET;
		end else if (take) begin
			if (fifo_out.bad) begin
				state_q <= RSS_HUNT; // [R1]
			end else if (fifo_out.data == `RSS_CHAR_XOFF) begin
				state_q <= RSS_HIGH; // [R2] an xoff always starts afresh
			end else begin
				case (state_q)
					RSS_HIGH: begin
						hi_q <= hv[3:0];
						state_q <= hv[4] ? RSS_HUNT : RSS_LOW; // [R13]
					end
					RSS_LOW: begin
						cmd_addr_q <= {hi_q, hv[3:0]}; // [R3]
						state_q <= hv[4] ? RSS_HUNT : RSS_TAIL; // [R13]
					end
					default: begin
						state_q <= RSS_HUNT;
					end
				endcase
			end
		end
	end

	// selection follows each complete command
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			sel_q <= 1'b0;
		end else if (take && !fifo_out.bad && state_q == RSS_TAIL
				&& fifo_out.data == `RSS_CHAR_SOH) begin
			sel_q <= (cmd_addr_q == station_addr); // [R5] [R12]
		end
	end

	// ==========================================
	// pass-through; five register stages counting the synchroniser, no storage, so any rate
	// the host picks after selection passes unchanged
	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			tx232_out <= 1'b1;
			tx485_out <= 1'b1;
			tx485_oe_n <= 1'b1;
			sel_led <= 1'b0;
		end else begin
			tx232_out <= sel_q ? rx485_s : 1'b1; // [R6] [R7] [R9]
			tx485_out <= rx232_s; // [R6] [R7]
			// four-wire drives whole time selected; two-wire only while a
			// low bit is sent, the line bias gives the idle high
			tx485_oe_n <= !(sel_q && (four_wire || !rx232_s)); // [R11]
			sel_led <= sel_q; // [R10]
		end
	end
endmodule

//--- tb/rss_host_model.sv
// host model driving the shared rs485 line
`timescale 1ns/10ps
module rss_host_model (
	input wire logic core_clk,
	output logic rs485_line
);
	initial rs485_line = 1'b1; // biased idle level
	// hold a level for n clocks; entered and left just after an edge
	task automatic hold(input logic v, input int n);
		rs485_line = v;
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	// one 8n1 frame, lsb first, at the given bit length
	task automatic send_char(input logic [7:0] c, input int bc);
		hold(1'b0, bc);
		for (int i = 0; i < 8; i++) hold(c[i], bc);
		hold(1'b1, bc);
	endtask
	// selection command: xoff, two hex digits, soh, then idle
	task automatic send_cmd(input logic [7:0] hi, input logic [7:0] lo, input int bc);
		send_char(8'h13, bc);
		send_char(hi, bc);
		send_char(lo, bc);
		send_char(8'h01, bc);
		hold(1'b1, 3 * bc);
	endtask
endmodule

//--- tb/rss_switch_props.sv
// port checker for the addressed serial switch
`timescale 1ns/10ps
module rss_switch_props (
	input wire logic core_clk,
	input wire logic sys_rst,
	input wire logic rx485_pin,
	input wire logic tx485_out,
	input wire logic tx485_oe_n,
	input wire logic rx232_pin,
	input wire logic tx232_out,
	input wire logic [7:0] addr_sw,
	input wire logic duplex4_strap,
	input wire logic cmd_pause,
	input wire logic sel_led,
	input wire logic char_overrun
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (sys_rst);
	// ==========================================
	// sequences
	// indicator dark long enough that the internal select has settled too
	sequence s_dark;
		!sel_led[*3];
	endsequence
	// selected in four-wire mode long enough for the strap to clear its
	// synchroniser and the enable register, still selected one edge on
	sequence s_four_held;
		(sel_led && duplex4_strap)[*6] ##1 sel_led;
	endsequence
	// ==========================================
	// assertions
	a_reset_quiet:
		assert property ($fell(sys_rst) |-> tx232_out && tx485_out && tx485_oe_n && !sel_led
			&& !char_overrun) else $error("outputs not at rest after reset");
	a_dark_tx_idle:
		assert property (s_dark |-> tx232_out) else $error("unselected station drives data");
	a_dark_oe_off:
		assert property (s_dark |-> tx485_oe_n) else $error("unselected station drives line");
	a_pass_to_host:
		assert property ($stable(rx232_pin)[*8] |-> tx485_out == rx232_pin)
			else $error("instrument data not forwarded");
	a_pass_to_inst:
		assert property ((sel_led && $stable(rx485_pin))[*8] |-> tx232_out == rx485_pin)
			else $error("host data not forwarded");
	a_four_drive:
		assert property (s_four_held |-> !$past(tx485_oe_n)) else $error("four-wire not driven");
	a_two_idle:
		assert property ((sel_led && !duplex4_strap && rx232_pin)[*8] |-> tx485_oe_n)
			else $error("two-wire drives a high level");
	a_led_quiet_line:
		assert property ($changed(sel_led) |-> rx485_pin && $past(rx485_pin, 4))
			else $error("select changed outside a stop bit");
	a_overrun_pulse:
		assert property (char_overrun |-> $past(cmd_pause) ##1 !char_overrun)
			else $error("overrun pulse malformed");
endmodule
bind rss_switch rss_switch_props u_props (.core_clk(core_clk), .sys_rst(sys_rst),
	.rx485_pin(rx485_pin), .tx485_out(tx485_out), .tx485_oe_n(tx485_oe_n),
	.rx232_pin(rx232_pin), .tx232_out(tx232_out), .addr_sw(addr_sw),
	.duplex4_strap(duplex4_strap), .cmd_pause(cmd_pause), .sel_led(sel_led),
	.char_overrun(char_overrun));

//--- tb/rss_switch_tb_top.sv
// self-checking bench for the addressed serial switch
`timescale 1ns/10ps
module rss_switch_tb_top;
	localparam int BC = 16; // scaled command bit length
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic rx232_pin = 1'b1;
	logic [7:0] addr_sw = 8'h00;
	logic duplex4_strap = 1'b1;
	logic cmd_pause = 1'b0;
	logic rx485_pin, tx485_out, tx485_oe_n, tx232_out, sel_led, char_overrun;
	int n_mismatch = 0;
	int check_count = 0;
	int n_ovr = 0; // overrun pulses seen
	always #4 core_clk = ~core_clk;
	always @(posedge core_clk) if (char_overrun === 1'b1) n_ovr++;
	rss_host_model host (.core_clk(core_clk), .rs485_line(rx485_pin));
	rss_switch #(.BIT_CYCLES(BC), .FIFO_DEPTH(16)) dut (.core_clk(core_clk),
		.sys_rst(sys_rst), .rx485_pin(rx485_pin), .tx485_out(tx485_out),
		.tx485_oe_n(tx485_oe_n), .rx232_pin(rx232_pin), .tx232_out(tx232_out),
		.addr_sw(addr_sw), .duplex4_strap(duplex4_strap), .cmd_pause(cmd_pause),
		.sel_led(sel_led), .char_overrun(char_overrun));
	// ==========================================
	// helpers
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_clk(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic give_verdict;
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// ==========================================
	// scenarios
	task automatic t_zero_addr;
		check("rest sel", {7'h00, sel_led}, 8'h00);
		check("rest pins", {4'h0, tx232_out, tx485_out, tx485_oe_n, char_overrun}, 8'h0e);
		host.send_cmd("0", "0", BC);
		check("sel zero", {7'b0, sel_led}, 8'h01);
	endtask
	task automatic t_forward;
		host.hold(1'b0, 10);
		check("to inst low", {7'b0, tx232_out}, 8'h00);
		host.hold(1'b1, 10);
		rx232_pin = 1'b0;
		wait_clk(8);
		check("to host low", {6'b0, tx485_out, tx485_oe_n}, 8'h00);
		rx232_pin = 1'b1;
		duplex4_strap = 1'b0;
		wait_clk(10);
		check("two wire idle", {6'b0, tx485_out, tx485_oe_n}, 8'h03);
		rx232_pin = 1'b0;
		wait_clk(8);
		check("two wire low", {6'b0, tx485_out, tx485_oe_n}, 8'h00);
		rx232_pin = 1'b1;
		// host moves to a faster rate; each bit must still come through
		fork
			host.send_char(8'h55, BC / 2);
			for (int i = 0; i < 10; i++) begin
				wait_clk(i == 0 ? 10 : BC / 2);
				check("fast bit", {7'b0, tx232_out}, 8'(i % 2));
			end
		join
		// the first low pulse looked like a start bit to the command receiver;
		// idle until that frame is over so the next xoff is not swallowed
		host.hold(1'b1, 10 * BC);
	endtask
	task automatic t_other_addr;
		host.send_cmd("0", "5", BC);
		check("deselect", {7'b0, sel_led}, 8'h00);
		host.hold(1'b0, 10);
		check("blocked", {7'b0, tx232_out}, 8'h01);
		host.hold(1'b1, 10 * BC); // let the phantom frame finish
	endtask
	task automatic t_refused;
		addr_sw = 8'h80; // a non-hex digit taken as zero would match here
		host.send_cmd("8", "G", BC);
		check("bad hex", {7'b0, sel_led}, 8'h00);
		addr_sw = 8'h8f;
		host.send_cmd("8", "F", BC / 2);
		// a misframed tail may still be in the receiver; give it a full frame
		host.hold(1'b1, 10 * BC);
		check("bad rate", {7'b0, sel_led}, 8'h00);
		host.send_cmd("8", "f", BC);
		check("sel 8f", {7'b0, sel_led}, 8'h01);
	endtask
	task automatic t_overrun;
		cmd_pause = 1'b1;
		for (int i = 0; i < 17; i++) host.send_char("Z", BC);
		wait_clk(BC);
		check("overruns", 8'(n_ovr), 8'h01);
		cmd_pause = 1'b0;
		wait_clk(40);
		check("junk ignored", {7'b0, sel_led}, 8'h01);
	endtask
	// ==========================================
	// main sequence and watchdog
	initial begin
		wait_clk(20);
		sys_rst = 1'b0;
		wait_clk(6);
		t_zero_addr();
		t_forward();
		t_other_addr();
		t_refused();
		t_overrun();
		give_verdict();
	end
	initial begin
		repeat (30000) @(posedge core_clk);
		n_mismatch++;
		give_verdict();
	end
endmodule
